// ### rtl/pmt_pkg.sv
// Purpose: Shared constants for the period match timer
// Assumes: 8-bit register port, one clock domain
// Notes:   Register offsets are local choices
package pmt_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [2:0] PMT_OFF_COUNT   = 3'h0;
	localparam logic [2:0] PMT_OFF_PERIOD  = 3'h1;
	localparam logic [2:0] PMT_OFF_CONTROL = 3'h2;
	localparam logic [2:0] PMT_OFF_STATUS  = 3'h3;
	localparam logic [2:0] PMT_OFF_MASK    = 3'h4;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int         PMT_CTL_ON_BIT    = 2;
	localparam int         PMT_CTL_PS_LO     = 0;
	localparam int         PMT_CTL_POST_LO   = 3;
	localparam logic [7:0] PMT_CTL_WR_MASK   = 8'h7f;
	localparam logic [7:0] PMT_PERIOD_RESET  = 8'hff;
	localparam logic [7:0] PMT_COUNT_RESET   = 8'h00;
	localparam logic [7:0] PMT_CONTROL_RESET = 8'h00;
	localparam int         PMT_IRQ_MATCH_BIT = 0;

	// ----------------------------------------
	// Instruction clock: system clock divided by four
	// ----------------------------------------
	localparam int         PMT_ICLK_DIV      = 4;

	// Prescale selection codes
	typedef enum logic [1:0] {
		PMT_PS_1  = 2'b00,
		PMT_PS_4  = 2'b01,
		PMT_PS_16 = 2'b10
	} pmt_ps_t;

endpackage

// ### rtl/pmt_prescaler.sv
// Purpose: Instruction clock and selectable input prescaler
// Assumes: Clear has priority over counting
// Notes:   Emits a one-cycle tick per prescaled period
`timescale 1ns/10ps
`default_nettype none
module pmt_prescaler #(
	parameter int ICLK_DIV = 4
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       run_i,
	input  wire logic       clear_i,
	input  wire logic [1:0] sel_i,
	output logic            tick_o
);
	import pmt_pkg::*;

	initial begin
		if (ICLK_DIV < 1 || ICLK_DIV > 16) begin
			$error("ICLK_DIV out of range");
		end
	end

	logic [3:0] iclk_cnt_r;
	logic [3:0] ps_cnt_r;
	logic       iclk_w;
	logic [3:0] ps_top_w;
	logic       ps_wrap_w;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Instruction clock: oscillator divided by four
	assign iclk_w    = run_i && (iclk_cnt_r == 4'(ICLK_DIV - 1));
	// Upper select bit forces divide by 16
	assign ps_top_w  = sel_i[1] ? 4'hf :
	                   (sel_i == PMT_PS_4) ? 4'h3 : 4'h0;
	assign ps_wrap_w = (ps_cnt_r >= ps_top_w);
	assign tick_o    = iclk_w && ps_wrap_w && !clear_i;

	// Counters hold while stopped
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			iclk_cnt_r <= 4'h0;
			ps_cnt_r   <= 4'h0;
		end else if (clear_i) begin
			iclk_cnt_r <= 4'h0;
			ps_cnt_r   <= 4'h0;
		end else if (run_i) begin
			iclk_cnt_r <= iclk_w ? 4'h0 : iclk_cnt_r + 4'h1;
			if (iclk_w) begin
				ps_cnt_r <= ps_wrap_w ? 4'h0 : ps_cnt_r + 4'h1;
			end
		end
	end

endmodule
`default_nettype wire

// ### rtl/pmt_postscaler.sv
// Purpose: Four-bit output postscaler on match pulses
// Assumes: Match pulses are one cycle long
// Notes:   Clear has priority
`timescale 1ns/10ps
`default_nettype none
module pmt_postscaler (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       clear_i,
	input  wire logic       match_i,
	input  wire logic [3:0] sel_i,
	output logic            event_o
);
	import pmt_pkg::*;

	logic [3:0] post_cnt_r;
	logic       last_w;

	// ----------------------------------------
	// Terminal decode
	// ----------------------------------------
	// Code n gives ratio n+1
	assign last_w  = (post_cnt_r >= sel_i);
	assign event_o = match_i && last_w && !clear_i;

	// Count match pulses
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			post_cnt_r <= 4'h0;
		end else if (clear_i) begin
			post_cnt_r <= 4'h0;
		end else if (match_i) begin
			post_cnt_r <= last_w ? 4'h0 : post_cnt_r + 4'h1;
		end
	end

endmodule
`default_nettype wire

// ### rtl/pmt_timer.sv
// Purpose: 8-bit period match timer with prescaler and postscaler
// Assumes: Register port on the system clock, 100 MHz
// Notes:   Match pulse feeds PWM units and serial shift clock
`timescale 1ns/10ps
`default_nettype none

module pmt_timer (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	output logic            irq_o,
	output logic            pwm_match_o,
	output logic            shift_clk_o
);
	import pmt_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] timer_count_r;
	logic [7:0] timer_count_nxt;
	logic [7:0] period_value_r;
	logic [6:0] timer_control_r;
	logic       match_irq_flag_r;
	logic       match_irq_enable_r;
	logic       shift_clk_r;
	logic [7:0] rdata_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic       wr_count_w;
	logic       wr_period_w;
	logic       wr_control_w;
	logic       wr_status_w;
	logic       wr_mask_w;
	logic       scaler_clr_w;
	logic       timer_on_w;
	logic       tick_w;
	logic       match_w;
	logic       count_eq_w;
	logic       post_evt_w;
	logic [1:0] clock_prescale_sel_w;
	logic [3:0] output_postscale_sel_w;
	logic [7:0] rd_mux_w;

	assign wr_count_w   = wr_i && (addr_i == PMT_OFF_COUNT);
	assign wr_period_w  = wr_i && (addr_i == PMT_OFF_PERIOD);
	assign wr_control_w = wr_i && (addr_i == PMT_OFF_CONTROL);
	assign wr_status_w  = wr_i && (addr_i == PMT_OFF_STATUS);
	assign wr_mask_w    = wr_i && (addr_i == PMT_OFF_MASK);
	// Scalers restart on count or control writes
	assign scaler_clr_w = wr_count_w || wr_control_w;

	// Control fields
	assign timer_on_w             = timer_control_r[PMT_CTL_ON_BIT];
	assign clock_prescale_sel_w   = timer_control_r[PMT_CTL_PS_LO +: 2];
	assign output_postscale_sel_w = timer_control_r[PMT_CTL_POST_LO +: 4];

	// Compare every cycle; the match fires on the tick that would pass the
	// period, so a period of n gives n+1 ticks and a single-cycle pulse
	assign count_eq_w = (timer_count_r == period_value_r);
	assign match_w    = timer_on_w && tick_w && count_eq_w;

	// ----------------------------------------
	// Scalers
	// ----------------------------------------
	pmt_prescaler #(
		.ICLK_DIV (PMT_ICLK_DIV)
	) u_pre (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.run_i    (timer_on_w),
		.clear_i  (scaler_clr_w),
		.sel_i    (clock_prescale_sel_w),
		.tick_o   (tick_w)
	);

	pmt_postscaler u_post (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.clear_i  (scaler_clr_w),
		.match_i  (match_w),
		.sel_i    (output_postscale_sel_w),
		.event_o  (post_evt_w)
	);

	// ----------------------------------------
	// Count next value
	// ----------------------------------------
	// Software write wins over increment and reload
	always_comb begin
		timer_count_nxt = timer_count_r;
		if (wr_count_w) begin
			timer_count_nxt = wdata_i;
		end else if (match_w) begin
			timer_count_nxt = PMT_COUNT_RESET;
		end else if (tick_w) begin
			timer_count_nxt = timer_count_r + 8'h01;
		end
	end

	// Count register; control writes do not touch it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			timer_count_r <= PMT_COUNT_RESET;
		end else begin
			timer_count_r <= timer_count_nxt;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			period_value_r     <= PMT_PERIOD_RESET;
			timer_control_r    <= PMT_CONTROL_RESET[6:0];
			match_irq_enable_r <= 1'b0;
		end else begin
			if (wr_period_w) begin
				period_value_r <= wdata_i;
			end
			if (wr_control_w) begin
				// Bit 7 not stored
				timer_control_r <= wdata_i[6:0] & PMT_CTL_WR_MASK[6:0];
			end
			if (wr_mask_w) begin
				match_irq_enable_r <= wdata_i[PMT_IRQ_MATCH_BIT];
			end
		end
	end

	// Sticky flag, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			match_irq_flag_r <= 1'b0;
		end else if (post_evt_w) begin
			match_irq_flag_r <= 1'b1;
		end else if (wr_status_w && wdata_i[PMT_IRQ_MATCH_BIT]) begin
			match_irq_flag_r <= 1'b0;
		end
	end

	// Level interrupt gated by enable
	assign irq_o = match_irq_flag_r && match_irq_enable_r;

	// ----------------------------------------
	// Outputs to partner units
	// ----------------------------------------
	// Unscaled match as PWM time base
	assign pwm_match_o = match_w;

	// Shift clock toggles per match, giving a 50% duty clock
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_clk_r <= 1'b0;
		end else if (match_w) begin
			shift_clk_r <= ~shift_clk_r;
		end
	end
	assign shift_clk_o = shift_clk_r;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Unmapped addresses read zero
	assign rd_mux_w =
		(addr_i == PMT_OFF_COUNT)   ? timer_count_r :
		(addr_i == PMT_OFF_PERIOD)  ? period_value_r :
		(addr_i == PMT_OFF_CONTROL) ? {1'b0, timer_control_r} :
		(addr_i == PMT_OFF_STATUS)  ? {7'h00, match_irq_flag_r} :
		(addr_i == PMT_OFF_MASK)    ? {7'h00, match_irq_enable_r} :
		8'h00;

	// Data valid only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_r <= 8'h00;
		end else if (rd_i) begin
			rdata_r <= rd_mux_w;
		end else begin
			rdata_r <= 8'h00;
		end
	end
	assign rdata_o = rdata_r;

endmodule
`default_nettype wire

// ### tb/pmt_far_model.sv
// Purpose: PWM time base and serial shift clock consumer model
// Assumes: Match pulses are one cycle long
// Notes:   Gap is the cycle distance between the last two matches
`timescale 1ns/10ps
`default_nettype none
module pmt_far_model (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        match_i,
	input  wire logic        shift_clk_i,
	output logic      [15:0] match_cnt_o,
	output logic      [15:0] gap_o
);
	logic [15:0] run_r;
	logic        shift_q_r;
	// PWM time base: count matches and time between them
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			match_cnt_o <= 16'h0000;
			gap_o       <= 16'h0000;
			run_r       <= 16'h0000;
			shift_q_r   <= 1'b0;
		end else begin
			shift_q_r <= shift_clk_i;
			run_r     <= match_i ? 16'h0000 : run_r + 16'h0001;
			if (match_i) begin
				match_cnt_o <= match_cnt_o + 16'h0001;
				gap_o       <= run_r + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/pmt_timer_props.sv
// Purpose: Port checks for the period match timer
// Assumes: Shadow copies follow software writes
// Notes:   Only top ports are visible here
`timescale 1ns/10ps
`default_nettype none
module pmt_timer_props
	import pmt_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] rdata_o,
	input  wire logic       irq_o,
	input  wire logic       pwm_match_o,
	input  wire logic       shift_clk_o
);
	logic [7:0] ctl_r;
	logic [7:0] per_r;
	logic       msk_r;
	// Address decode
	wire wr_ctl = wr_i && addr_i == PMT_OFF_CONTROL;
	wire wr_per = wr_i && addr_i == PMT_OFF_PERIOD;
	wire wr_msk = wr_i && addr_i == PMT_OFF_MASK;
	// Shadow state, so reads can be judged without the body
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl_r <= PMT_CONTROL_RESET;
			per_r <= PMT_PERIOD_RESET;
			msk_r <= 1'b0;
		end else begin
			if (wr_ctl) ctl_r <= wdata_i & PMT_CTL_WR_MASK;
			if (wr_per) per_r <= wdata_i;
			if (wr_msk) msk_r <= wdata_i[0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	ctl_read_a: assert property (rd_i && addr_i == PMT_OFF_CONTROL
		|=> rdata_o == {1'b0, $past(ctl_r[6:0])}) else $error("control read");
	per_read_a: assert property (rd_i && addr_i == PMT_OFF_PERIOD
		|=> rdata_o == $past(per_r)) else $error("period read");
	msk_read_a: assert property (rd_i && addr_i == PMT_OFF_MASK
		|=> rdata_o[0] == $past(msk_r)) else $error("mask read");
	unmapped_read_a: assert property (rd_i && addr_i > PMT_OFF_MASK
		|=> rdata_o == 8'h00) else $error("unmapped read");
	off_quiet_a: assert property (!ctl_r[PMT_CTL_ON_BIT] |-> !pwm_match_o)
		else $error("match while off");
	irq_mask_a: assert property (irq_o |-> msk_r)
		else $error("irq while masked");
	match_once_a: assert property (pwm_match_o |=> !pwm_match_o)
		else $error("match pulse too long");
	shift_toggle_a: assert property (pwm_match_o
		|=> shift_clk_o != $past(shift_clk_o)) else $error("shift no toggle");
	shift_hold_a: assert property (!pwm_match_o |=> $stable(shift_clk_o))
		else $error("shift moved");
	match_c: cover property (pwm_match_o);
	irq_c: cover property ($rose(irq_o));
	ctl_rd_c: cover property (rd_i && addr_i == PMT_OFF_CONTROL);
endmodule
bind pmt_timer pmt_timer_props u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .irq_o(irq_o), .pwm_match_o(pwm_match_o),
	.shift_clk_o(shift_clk_o));
`default_nettype wire

// ### tb/tb_period_match_timer8.sv
// Purpose: Self-checking bench for the period match timer
// Assumes: Register port with one-cycle read latency
// Notes:   Random periods from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
module tb_period_match_timer8;
	import pmt_pkg::*;
	logic        clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [2:0]  addr_i = 3'h0;
	logic [7:0]  wdata_i = 8'h00;
	wire  logic [7:0]  rdata_o;
	wire  logic        irq_o;
	wire  logic        pwm_match_o;
	wire  logic        shift_clk_o;
	wire  logic [15:0] mcnt;
	wire  logic [15:0] gap;
	int          error_cnt = 0;
	int          checks_done = 0;
	logic [31:0] seed = 32'd74080;
	logic [7:0]  d;
	logic [7:0]  p;
	logic [3:0]  posts [3] = '{4'h0, 4'h5, 4'hf};
	pmt_timer u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.irq_o(irq_o), .pwm_match_o(pwm_match_o), .shift_clk_o(shift_clk_o));
	pmt_far_model u_far (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.match_i(pwm_match_o), .shift_clk_i(shift_clk_o),
		.match_cnt_o(mcnt), .gap_o(gap));
	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Expected match spacing in system clocks
	function automatic logic [15:0] exp_gap(logic [7:0] per, logic [1:0] ps);
		return 16'((per + 1) * PMT_ICLK_DIV * (ps == 2'b00 ? 1 : ps == 2'b01 ? 4 : 16));
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// Bounded wait for n further match pulses
	task automatic wait_m(input int n);
		int s;
		s = mcnt;
		for (int k = 0; k < 4000 && mcnt < s + n; k++) @(posedge clk_i);
		#1 chk(16'(mcnt >= s + n), 16'h0001);
	endtask
	task automatic complete_run();
		$display("tests done: %0d checks, %0d mismatches", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Watchdog sized well above the longest test
	initial begin
		#900000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(PMT_OFF_COUNT, d);   chk(16'(d), 16'(PMT_COUNT_RESET));
		rd(PMT_OFF_PERIOD, d);  chk(16'(d), 16'h00ff);
		rd(PMT_OFF_CONTROL, d); chk(16'(d), 16'h0000);
		wr(3'h7, 8'h5a);
		rd(3'h7, d);            chk(16'(d), 16'h0000);
		$display("test reset done");
		p = 8'(rnd()) & 8'hfb;
		wr(PMT_OFF_CONTROL, p | 8'h80);
		rd(PMT_OFF_CONTROL, d); chk(16'(d), 16'(p & 8'h7f));
		p = 8'(rnd());
		wr(PMT_OFF_COUNT, p);
		repeat (20) @(posedge clk_i);
		rd(PMT_OFF_COUNT, d);   chk(16'(d), 16'(p));
		wr(PMT_OFF_CONTROL, 8'h00);
		rd(PMT_OFF_COUNT, d);   chk(16'(d), 16'(p));
		$display("test access done");
		for (int s = 0; s < 4; s++) begin
			p = 8'(rnd() % 8);
			wr(PMT_OFF_CONTROL, 8'h00);
			wr(PMT_OFF_PERIOD, p);
			wr(PMT_OFF_COUNT, 8'h00);
			wr(PMT_OFF_CONTROL, 8'h04 | 8'(s));
			wait_m(2);
			chk(gap, exp_gap(p, 2'(s)));
		end
		$display("test prescale done");
		wr(PMT_OFF_MASK, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr(PMT_OFF_CONTROL, 8'h00);
			wr(PMT_OFF_PERIOD, 8'h03);
			wr(PMT_OFF_STATUS, 8'h01);
			wr(PMT_OFF_COUNT, 8'h00);
			wr(PMT_OFF_CONTROL, {1'b0, posts[i], 3'b100});
			if (posts[i] != 4'h0) wait_m(int'(posts[i]));
			chk(16'(irq_o), 16'h0000);
			wait_m(1);
			chk(16'(irq_o), 16'h0001);
		end
		wr(PMT_OFF_MASK, 8'h00);
		#1 chk(16'(irq_o), 16'h0000);
		rd(PMT_OFF_STATUS, d);  chk(16'(d[0]), 16'h0001);
		wr(PMT_OFF_CONTROL, 8'h00);
		wr(PMT_OFF_STATUS, 8'h01);
		wr(PMT_OFF_MASK, 8'h01);
		#1 chk(16'(irq_o), 16'h0000);
		$display("test postscale done");
		complete_run();
	end
endmodule
`default_nettype wire
